// ===== rtl/tidl_core.v
// Counting, arithmetic and result registers of the time interval digitizer.
`include "tidl_map.vh"

// Functional notes
// - Interval split: start fine, coarse, stop fine.
// - Stretch factor 2048 on 20 ns clock.
// - Result equals N1/k plus N12 minus N2/k.
// - Coarse count includes each clock unambiguously.
// - Eight ranges (settings 7 and up all full scale), largest 340 ms, 9.76 ps.
// - First register shifts into second register.
// - Results hold until own register cleared.
// - Second register drives 35 indicator outputs.
// - Start accepted only when enabled, unvetoed.
// - Start gate high counts start scaler.
// - Start gate begins the main coarse burst.
// - Preset main count raises stop enable.
// - Stop pulses before stop enable ignored.
// - Stop gate high counts stop scaler.
// - Stop gate leading edge ends coarse count.
// - Add start count to complemented stop count.
// - Carries from bits 11, 12 join main.
// - Result: main scaler above eleven fine bits.
// - Completion transfers result, clears scalers, logic.
// - Inputs inhibited while conversion busy.
// - Overrun flagged when interval exceeds range.
// - Host reads, clears second; request while full.
module tidl_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        start_gate,
    input  wire        stop_gate,
    input  wire        veto,
    output reg         start_busy,
    output reg         stop_busy,
    output reg         stop_enable,
    output reg  [34:0] indicator,
    output reg         service_request,
    output reg         overrun
);

// ----------------------------------------------------------------------
// State codes
// ----------------------------------------------------------------------
localparam [2:0] ST_IDLE  = 3'd0;
localparam [2:0] ST_START = 3'd1;
localparam [2:0] ST_WAIT  = 3'd2;
localparam [2:0] ST_STOP  = 3'd3;
localparam [2:0] ST_ADD   = 3'd4;
localparam [2:0] ST_STORE = 3'd5;

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
reg  [2:0]  sync_a;
reg  [2:0]  sync_b;
wire        start_s = sync_b[0];
wire        stop_s  = sync_b[1];
wire        veto_s  = sync_b[2];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync_a <= 3'h0;
        sync_b <= 3'h0;
    end else begin
        sync_a <= {veto, stop_gate, start_gate};
        sync_b <= sync_a;
    end
end

// ----------------------------------------------------------------------
// Registers and scalers
// ----------------------------------------------------------------------
reg  [31:0] ctrl;
reg  [2:0]  state;
reg  [11:0] start_cnt;
reg  [11:0] stop_cnt;
reg  [23:0] main_cnt;
reg  [12:0] add_sum;
reg  [34:0] first_reg;
reg         first_full;
reg         second_full;
reg         stop_s_d;
reg  [23:0] stop_preset;
reg  [23:0] range_limit;

wire        enabled  = ctrl[`TIDL_CTRL_ENA_BIT];
wire [3:0]  range_sel = ctrl[`TIDL_CTRL_RANGE_MSB:`TIDL_CTRL_RANGE_LSB];
wire [3:0]  sen_sel  = ctrl[`TIDL_CTRL_SEN_MSB:`TIDL_CTRL_SEN_LSB];
wire        wr_en    = psel & penable & pwrite;
wire        clr_wr   = wr_en & (paddr == `TIDL_OFF_CLEAR);
wire        clr_first  = clr_wr & pwdata[`TIDL_CLR_FIRST_BIT];
wire        clr_second = clr_wr & pwdata[`TIDL_CLR_SECOND_BIT];
wire [12:0] fine_sum = {1'b0, start_cnt} + {1'b0, ~stop_cnt};
wire [1:0]  carries  = {add_sum[12], add_sum[11]};

// Range tables: coarse count reached for each switch position.
always @* begin
    stop_preset = {20'h00000, sen_sel} << (2 * sen_sel);
    if (range_sel >= 4'd9)
        range_limit = 24'hFFFFFF;
    else
        range_limit = (24'h000400 << (2 * range_sel)) - 24'h000001;
end

// ----------------------------------------------------------------------
// Conversion sequencer
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state       <= ST_IDLE;
        start_cnt   <= 12'h000;
        stop_cnt    <= 12'h000;
        main_cnt    <= 24'h000000;
        add_sum     <= 13'h0000;
        first_reg   <= 35'h0;
        first_full  <= 1'b0;
        second_full <= 1'b0;
        indicator   <= 35'h0;
        stop_enable <= 1'b0;
        start_busy  <= 1'b0;
        stop_busy   <= 1'b0;
        overrun     <= 1'b0;
        stop_s_d    <= 1'b0;
        service_request <= 1'b0;
    end else begin
        stop_s_d <= stop_s;
        overrun  <= 1'b0;
        case (state)
            ST_IDLE: begin
                start_cnt   <= 12'h000;
                stop_cnt    <= 12'h000;
                main_cnt    <= 24'h000000;
                stop_enable <= 1'b0;
                if (start_s && enabled && !veto_s && !first_full) begin
                    state      <= ST_START;
                    start_busy <= 1'b1;
                    stop_busy  <= 1'b1;
                    start_cnt  <= 12'h001;
                end
            end
            ST_START, ST_WAIT: begin
                if (start_s)
                    start_cnt <= start_cnt + 12'h001;
                main_cnt <= main_cnt + 24'h000001;
                if (main_cnt >= stop_preset)
                    stop_enable <= 1'b1;
                if (stop_enable && stop_s && !stop_s_d) begin
                    state    <= ST_STOP;
                    main_cnt <= main_cnt;
                    stop_cnt <= 12'h001;
                end else if (main_cnt == 24'hFFFFFF) begin
                    overrun <= 1'b1;
                    state   <= ST_IDLE;
                    stop_enable <= 1'b0;
                    start_busy <= 1'b0;
                    stop_busy  <= 1'b0;
                end else if (!start_s)
                    state <= ST_WAIT;
            end
            ST_STOP: begin
                if (stop_s)
                    stop_cnt <= stop_cnt + 12'h001;
                else if (!start_s)
                    state <= ST_ADD;
                if (start_s)
                    start_cnt <= start_cnt + 12'h001;
            end
            ST_ADD: begin
                add_sum <= fine_sum + 13'h0001;
                state   <= ST_STORE;
            end
            ST_STORE: begin
                first_reg  <= {main_cnt + {22'h0, carries}, add_sum[10:0]};
                first_full <= 1'b1;
                overrun    <= (main_cnt > range_limit);
                state      <= ST_IDLE;
                stop_enable <= 1'b0;
                start_busy <= 1'b0;
                stop_busy  <= 1'b0;
            end
            default: state <= ST_IDLE;
        endcase
        if (first_full && !second_full && state != ST_STORE) begin
            indicator   <= first_reg;
            second_full <= 1'b1;
            first_full  <= 1'b0;
        end else begin
            if (clr_first && state != ST_STORE)
                first_full <= 1'b0;
            if (clr_second) begin
                second_full <= 1'b0;
                indicator   <= 35'h0;
            end
        end
        service_request <= second_full & ~clr_second;
    end
end

// ----------------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl    <= `TIDL_CTRL_RESET;
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= 1'b0;
        if (psel && !penable) begin
            if (paddr == `TIDL_OFF_CTRL)
                prdata <= {20'h00000, ctrl[11:0]};
            else if (paddr == `TIDL_OFF_STATUS)
                prdata <= {27'h0, stop_enable, overrun, second_full, first_full, start_busy};
            else if (paddr == `TIDL_OFF_FIRST_LO)
                prdata <= first_reg[31:0];
            else if (paddr == `TIDL_OFF_FIRST_HI)
                prdata <= {29'h0, first_reg[34:32]};
            else if (paddr == `TIDL_OFF_SECOND_LO)
                prdata <= indicator[31:0];
            else if (paddr == `TIDL_OFF_SECOND_HI)
                prdata <= {29'h0, indicator[34:32]};
            else if (paddr == `TIDL_OFF_CLEAR)
                prdata <= 32'h00000000;
            else begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b1;
            end
        end
        if (wr_en && pready && paddr == `TIDL_OFF_CTRL)
            ctrl <= {20'h00000, pwdata[11:0]};
    end
end

endmodule // tidl_core

// ===== rtl/tidl_map.vh
// Constant map of the time interval digitizer logic: offsets, fields, resets and timing counts.
`ifndef TIDL_MAP_VH
`define TIDL_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TIDL_OFF_CTRL        12'h000
`define TIDL_OFF_STATUS      12'h004
`define TIDL_OFF_FIRST_LO    12'h008
`define TIDL_OFF_FIRST_HI    12'h00C
`define TIDL_OFF_SECOND_LO   12'h010
`define TIDL_OFF_SECOND_HI   12'h014
`define TIDL_OFF_CLEAR       12'h018

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TIDL_CTRL_ENA_BIT    0
`define TIDL_CTRL_RANGE_LSB  4
`define TIDL_CTRL_RANGE_MSB  7
`define TIDL_CTRL_SEN_LSB    8
`define TIDL_CTRL_SEN_MSB    11
`define TIDL_CTRL_RESET      32'h00000000

// ----------------------------------------------------------------------
// Clear register fields and status fields
// ----------------------------------------------------------------------
`define TIDL_CLR_FIRST_BIT   0
`define TIDL_CLR_SECOND_BIT  1
`define TIDL_ST_BUSY_BIT     0
`define TIDL_ST_FIRST_BIT    1
`define TIDL_ST_SECOND_BIT   2
`define TIDL_ST_OVR_BIT      3
`define TIDL_ST_SEN_BIT      4

// ----------------------------------------------------------------------
// Widths and arithmetic
// ----------------------------------------------------------------------
`define TIDL_STRETCH_K       2048
`define TIDL_FINE_W          12
`define TIDL_FINE_BITS       11
`define TIDL_MAIN_W          24
`define TIDL_RESULT_W        35
`define TIDL_RANGE_NUM       10
`define TIDL_MASTER_PS       20000
`define TIDL_LSB_FS          9766

`endif

// ===== test/test_time_interval_digitizer_logic.sv
// Self-checking bench of the digitizer core.
`include "tidl_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_time_interval_digitizer_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, veto, go, rerr, ovr_seen;
    logic        pready, pslverr, start_gate, stop_gate, start_busy, stop_busy, stop_enable, service_request, overrun;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [34:0] indicator, v;
    logic [10:0] n1, n2;
    logic [15:0] gap;
    int          n12, err_total, check_count, seed, n;
    longint      exp_q[$];
    tidl_core tidl_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_gate(start_gate), .stop_gate(stop_gate), .veto(veto), .start_busy(start_busy),
        .stop_busy(stop_busy), .stop_enable(stop_enable), .indicator(indicator),
        .service_request(service_request), .overrun(overrun));
    tidl_interp_model tidl_interp_model_inst (.pclk(pclk), .go(go), .n1(n1), .n2(n2), .gap(gap),
        .stop_enable(stop_enable), .start_gate(start_gate), .stop_gate(stop_gate), .n12(n12));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (overrun === 1'b1) ovr_seen <= 1'b1;
    task conclude;
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_total++;
            conclude;
        end
    endtask
    task rd35(input logic [11:0] a, output logic [34:0] r);
        apb(1'b0, a, 32'h00000000);
        r[31:0] = rdat;
        apb(1'b0, a + 12'h004, 32'h00000000);
        r[34:32] = rdat[2:0];
    endtask
    task ev(input int f1, input int f2, input int g);
        @(posedge pclk);
        n1 <= f1;
        n2 <= f2;
        gap <= g;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        while (start_busy !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        while (start_busy !== 1'b0 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 9000) begin
            err_total++;
            conclude;
        end
        repeat (3) @(posedge pclk);
        exp_q.push_back(longint'(n12) * 2048 + f1 - f2);
    endtask
    initial begin
        seed = 53036;
        err_total = 0;
        check_count = 0;
        ovr_seen = 1'b0;
        {presetn, psel, penable, pwrite, veto, go, paddr, pwdata, n1, n2, gap} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TIDL_OFF_CTRL, 32'h00000000);
        `CHK(rdat, `TIDL_CTRL_RESET)
        apb(1'b0, 12'h0FC, 32'h00000000);
        `CHK({rerr, rdat}, 33'h100000000)
        apb(1'b1, `TIDL_OFF_CTRL, 32'h00000191);
        veto <= 1'b1;
        ev(100, 50, 4);
        `CHK(start_busy, 1'b0)
        repeat (5100) @(posedge pclk);
        veto <= 1'b0;
        exp_q.delete();
        ev(16 + ($random(seed) & 1023), 1 + ($random(seed) & 1023), 2 + ($random(seed) & 15));
        rd35(`TIDL_OFF_SECOND_LO, v);
        `CHK(v, exp_q[0][34:0])
        `CHK({service_request, indicator}, {1'b1, exp_q[0][34:0]})
        ev(16 + ($random(seed) & 1023), 1 + ($random(seed) & 1023), 2 + ($random(seed) & 15));
        rd35(`TIDL_OFF_FIRST_LO, v);
        `CHK(v, exp_q[1][34:0])
        `CHK(indicator, exp_q[0][34:0])
        apb(1'b1, `TIDL_OFF_CLEAR, 32'h00000002);
        repeat (3) @(posedge pclk);
        rd35(`TIDL_OFF_SECOND_LO, v);
        `CHK(v, exp_q[1][34:0])
        apb(1'b1, `TIDL_OFF_CLEAR, 32'h00000003);
        repeat (3) @(posedge pclk);
        `CHK({service_request, indicator}, 36'h000000000)
        `CHK(ovr_seen, 1'b0)
        apb(1'b1, `TIDL_OFF_CTRL, 32'h00000101);
        ev(20, 10, 1100);
        `CHK(ovr_seen, 1'b1)
        conclude;
    end
endmodule // test_time_interval_digitizer_logic

// ===== test/tidl_core_monitor.sv
// Port checker of the digitizer core.
module tidl_core_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        start_gate,
    input wire logic        start_busy,
    input wire logic        stop_busy,
    input wire logic        stop_enable,
    input wire logic        service_request,
    input wire logic        overrun,
    input wire logic [34:0] indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_once_a: assert property (pready |=> !pready) else $error("ready too long");
    ready_setup_a: assert property (psel && !penable |=> pready) else $error("no answer");
    err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
    ovr_pulse_a: assert property (overrun |=> !overrun) else $error("overrun too long");
    busy_start_a: assert property ($rose(start_busy) |-> $past(start_gate, 3)) else $error("bad busy");
    enable_busy_a: assert property (stop_enable |-> start_busy) else $error("stray enable");
    stop_gated_a: assert property (!stop_enable && start_busy |=> start_busy) else $error("early stop");
    result_hold_a: assert property ($past(service_request) && !$past(psel && pwrite)
        && !$past(psel && pwrite, 2) |-> $stable(indicator)) else $error("result moved");
endmodule // tidl_core_monitor
bind tidl_core tidl_core_monitor tidl_core_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .start_gate(start_gate),
    .start_busy(start_busy), .stop_busy(stop_busy), .stop_enable(stop_enable),
    .service_request(service_request), .overrun(overrun), .indicator(indicator));

// ===== test/tidl_interp_model.sv
// Behavioural start and stop interpolator pair.
module tidl_interp_model (
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [10:0] n1,
    input  wire logic [10:0] n2,
    input  wire logic [15:0] gap,
    input  wire logic        stop_enable,
    output logic             start_gate,
    output logic             stop_gate,
    output int               n12
);
    timeunit 1ns;
    timeprecision 1ps;
    int t;
    initial begin
        start_gate = 1'b0;
        stop_gate = 1'b0;
        n12 = 0;
        forever begin
            @(posedge pclk);
            if (go === 1'b1) begin
                t = 0;
                start_gate <= 1'b1;
                stop_gate <= 1'b1;
                repeat (n1) begin
                    @(posedge pclk);
                    t++;
                    stop_gate <= 1'b0;
                end
                start_gate <= 1'b0;
                repeat (gap) begin
                    @(posedge pclk);
                    t++;
                end
                while (stop_enable !== 1'b1 && t < 5000) begin
                    @(posedge pclk);
                    t++;
                end
                stop_gate <= 1'b1;
                n12 = t + 1; // The coarse span runs on to the mark after the stop edge.
                repeat (n2) @(posedge pclk);
                stop_gate <= 1'b0;
            end
        end
    end
endmodule // tidl_interp_model
